//--- logic/fpim_map.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Only function codes 3, 16 and 23 are served; any other code gets an exception answer.
// - The input area starts at register address 0.
// - The output area starts at register address 1024.
// - Each register word carries its high byte first and its low byte second.
// - Input number n is bit n modulo eight of input byte n divided by eight.
// - Configured output n is stored in output byte n divided by eight at bit n modulo eight.
// - Inputs 0-7, 8-15 and 16-23 occupy bits 0-7 of input bytes 0, 1 and 2.
// - Outputs 0-7, 8-15 and 16-23 occupy bits 0-7 of output bytes 0, 1 and 2.
// - Output byte 3 bits 0-4 carry output, input and general error, maintenance, running.
// - Output byte 3 bit 5 is set while data exchange with the base unit is active.
// - Each exchange carries exactly twenty bytes in each direction.
// - Modbus traffic uses TCP port 502 and needs no connection setup.
// - The scanner reads the output image through assembly instance 0x64.
// - The scanner writes the input image through assembly instance 0x96.
module fpim_map
    import fpim_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic req_valid,
    input wire logic [15:0] req_tcp_port,
    input wire logic [7:0] req_function,
    input wire logic [15:0] req_read_addr,
    input wire logic [15:0] req_read_count,
    input wire logic [15:0] req_write_addr,
    input wire logic [15:0] req_write_count,
    input wire logic [15:0] req_write_word,
    input wire logic [3:0] req_write_index,
    input wire logic req_write_strobe,
    input wire logic [3:0] rsp_word_index,
    input wire logic asm_write_valid,
    input wire logic [7:0] asm_instance,
    input wire logic [IMAGE_BYTES*8-1:0] asm_write_image,
    input wire logic [IO_POINTS-1:0] base_outputs,
    input wire logic [IO_POINTS-1:0] base_output_used,
    input wire logic output_error_led,
    input wire logic input_error_led,
    input wire logic general_error_led,
    input wire logic maintenance_message_led,
    input wire logic running_led,
    input wire logic exchange_active,
    output logic rsp_valid,
    output logic rsp_exception,
    output logic [7:0] rsp_exception_code,
    output logic [15:0] rsp_word,
    output logic [IMAGE_BYTES*8-1:0] asm_read_image,
    output logic [IMAGE_BYTES*8-1:0] base_input_image,
    output logic [IO_POINTS-1:0] base_inputs
);

    //----------------------------------------------------------------
    // Helpers
    //----------------------------------------------------------------
    // Selects byte b of an image; byte 0 holds bits 7..0.
    function automatic logic [7:0] img_byte(input logic [IMAGE_BYTES*8-1:0] img, input int b);
        img_byte = img[b*8 +: 8];
    endfunction

    // A span is legal when it is not empty and fits inside the twenty-byte area.
    function automatic logic span_ok(input logic [15:0] addr, input logic [15:0] cnt,
                                     input logic [15:0] base);
        logic [16:0] off;
        off = {1'b0, addr} - {1'b0, base};
        span_ok = (addr >= base) && (cnt != 16'h0000) && (cnt <= IMAGE_WORDS_W)
                  && ((off + {1'b0, cnt}) <= {1'b0, IMAGE_WORDS_W});
    endfunction

    typedef struct packed {
        logic rsp_valid;
        logic rsp_exception;
        logic [7:0] rsp_exception_code;
        logic rsp_read;
        logic [15:0] rsp_read_off;
        logic [15:0] wr_off;
        logic [IMAGE_BYTES*8-1:0] in_image;
        logic [IMAGE_BYTES*8-1:0] out_image;
    } fpim_state_s;

    fpim_state_s state_reg;
    fpim_state_s state_next;

    //----------------------------------------------------------------
    // Next state
    //----------------------------------------------------------------
    always_comb begin
        logic fc_ok;
        logic rd_ok;
        logic wr_ok;
        logic is_rd;
        logic is_wr;
        logic [15:0] w;
        int idx;
        fc_ok = 1'b0;
        rd_ok = 1'b0;
        wr_ok = 1'b0;
        is_rd = 1'b0;
        is_wr = 1'b0;
        w = 16'h0000;
        idx = 0;
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;

        // Output area image, rebuilt every cycle from the base unit.
        state_next.out_image = '0;
        for (int n = 0; n < IO_POINTS; n++) begin
            state_next.out_image[(n / 8) * 8 + (n % 8)] =
                base_outputs[n] & base_output_used[n];
        end
        state_next.out_image[STATUS_BYTE*8 + ST_OUTPUT_ERROR] = output_error_led;
        state_next.out_image[STATUS_BYTE*8 + ST_INPUT_ERROR] = input_error_led;
        state_next.out_image[STATUS_BYTE*8 + ST_GENERAL_ERROR] = general_error_led;
        state_next.out_image[STATUS_BYTE*8 + ST_MAINTENANCE] = maintenance_message_led;
        state_next.out_image[STATUS_BYTE*8 + ST_RUNNING] = running_led;
        state_next.out_image[STATUS_BYTE*8 + ST_EXCHANGE] = exchange_active;

        // Modbus request decode; only port 502 traffic is served.
        if (req_valid && (req_tcp_port == MODBUS_TCP_PORT)) begin
            case (req_function)
                FC_READ_HOLDING: begin
                    fc_ok = 1'b1;
                    is_rd = 1'b1;
                end
                FC_WRITE_MULTIPLE: begin
                    fc_ok = 1'b1;
                    is_wr = 1'b1;
                end
                FC_READ_WRITE_MULTIPLE: begin
                    fc_ok = 1'b1;
                    is_rd = 1'b1;
                    is_wr = 1'b1;
                end
                default: begin
                    fc_ok = 1'b0;
                end
            endcase
            rd_ok = !is_rd || span_ok(req_read_addr, req_read_count, OUTPUT_AREA_BASE);
            wr_ok = !is_wr || span_ok(req_write_addr, req_write_count, INPUT_AREA_BASE);
            state_next.rsp_valid = 1'b1;
            state_next.rsp_exception = !(fc_ok && rd_ok && wr_ok);
            state_next.rsp_exception_code = !fc_ok ? EXC_ILLEGAL_FUNCTION :
                (!(rd_ok && wr_ok) ? EXC_ILLEGAL_ADDRESS : 8'h00);
            state_next.rsp_read = is_rd && fc_ok && rd_ok && wr_ok;
            state_next.rsp_read_off = req_read_addr - OUTPUT_AREA_BASE;
            state_next.wr_off = req_write_addr - INPUT_AREA_BASE;
        end

        // Data words of any write strobe that lands inside the image, high byte first; the request is not checked for acceptance.
        if (req_write_strobe) begin
            idx = int'(state_reg.wr_off) + int'(req_write_index);
            if (idx < IMAGE_WORDS) begin
                w = req_write_word;
                state_next.in_image[idx*16 +: 8] = w[15:8];
                state_next.in_image[idx*16 + 8 +: 8] = w[7:0];
            end
        end

        // Assembly write of the whole twenty-byte input image.
        if (asm_write_valid && (asm_instance == ASM_INPUT_INSTANCE)) begin
            state_next.in_image = asm_write_image;
        end

        if (sys_rst) begin
            state_next = '0;
        end
    end

    always_ff @(posedge clock) begin
        state_reg <= state_next;
    end

    //----------------------------------------------------------------
    // Outputs
    //----------------------------------------------------------------
    logic [15:0] rd_word;
    int rd_idx;
    always_comb begin
        rd_idx = int'(state_reg.rsp_read_off) + int'(rsp_word_index);
        rd_word = 16'h0000;
        if (state_reg.rsp_read && (rd_idx < IMAGE_WORDS)) begin
            rd_word = {img_byte(state_reg.out_image, rd_idx*2),
                       img_byte(state_reg.out_image, rd_idx*2 + 1)};
        end
    end

    assign rsp_valid = state_reg.rsp_valid;
    assign rsp_exception = state_reg.rsp_exception;
    assign rsp_exception_code = state_reg.rsp_exception_code;
    assign rsp_word = rd_word;
    assign asm_read_image = state_reg.out_image;
    assign base_input_image = state_reg.in_image;
    assign base_inputs = state_reg.in_image[IO_POINTS-1:0];

    //----------------------------------------------------------------
    // Assertions
    //----------------------------------------------------------------
    property p_bad_fc;
        @(posedge clock) disable iff (sys_rst)
        req_valid && req_tcp_port == MODBUS_TCP_PORT && req_function != FC_READ_HOLDING
        && req_function != FC_WRITE_MULTIPLE && req_function != FC_READ_WRITE_MULTIPLE
        |=> rsp_valid && rsp_exception && rsp_exception_code == EXC_ILLEGAL_FUNCTION;
    endproperty
    a_bad_fc: assert property (p_bad_fc) else $error("Unsupported code not refused.");

    property p_in_base;
        @(posedge clock) disable iff (sys_rst)
        req_valid && req_tcp_port == MODBUS_TCP_PORT && req_function == FC_WRITE_MULTIPLE
        && req_write_addr == INPUT_AREA_BASE && req_write_count == 16'h0001
        |=> !rsp_exception;
    endproperty
    a_in_base: assert property (p_in_base) else $error("Input base not accepted.");

    property p_out_base;
        @(posedge clock) disable iff (sys_rst)
        req_valid && req_tcp_port == MODBUS_TCP_PORT && req_function == FC_READ_HOLDING
        && req_read_addr == OUTPUT_AREA_BASE && req_read_count != 16'h0000
        && req_read_count <= IMAGE_WORDS_W
        |=> !rsp_exception ##0 (rsp_word_index != 4'h0 || rsp_word[15:8] == asm_read_image[7:0]);
    endproperty
    a_out_base: assert property (p_out_base) else $error("Output base wrong.");

    property p_word_order;
        @(posedge clock) disable iff (sys_rst)
        $past(req_write_strobe) && !$past(asm_write_valid) && $past(state_reg.wr_off) == 16'h0000
        && $past(req_write_index) == 4'h0 && !$past(sys_rst)
        |-> base_input_image[15:0] == {$past(req_write_word[7:0]), $past(req_write_word[15:8])};
    endproperty
    a_word_order: assert property (p_word_order) else $error("Byte order wrong.");

    property p_twelve;
        @(posedge clock) disable iff (sys_rst)
        $past(req_write_strobe) && !$past(asm_write_valid) && $past(state_reg.wr_off) == 16'h0000
        && $past(req_write_index) == 4'h0 && !$past(sys_rst)
        |-> base_inputs[12] == $past(req_write_word[4]);
    endproperty
    a_twelve: assert property (p_twelve) else $error("Input twelve misplaced.");

    property p_out5;
        @(posedge clock) disable iff (sys_rst)
        !$past(sys_rst) && $past(base_output_used[5])
        |-> asm_read_image[5] == $past(base_outputs[5])
        && asm_read_image[16] == ($past(base_outputs[16]) & $past(base_output_used[16]));
    endproperty
    a_out5: assert property (p_out5) else $error("Output placement wrong.");

    property p_leds;
        @(posedge clock) disable iff (sys_rst)
        !$past(sys_rst)
        |-> asm_read_image[28:24] == {$past(running_led), $past(maintenance_message_led),
            $past(general_error_led), $past(input_error_led), $past(output_error_led)};
    endproperty
    a_leds: assert property (p_leds) else $error("Indicator bits wrong.");

    property p_exch;
        @(posedge clock) disable iff (sys_rst)
        $rose(exchange_active) |=> asm_read_image[29];
    endproperty
    a_exch: assert property (p_exch) else $error("Exchange flag late.");

    property p_zero;
        @(posedge clock) disable iff (sys_rst)
        asm_read_image[31:30] == 2'b00 && asm_read_image[IMAGE_BYTES*8-1:32] == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("Unused bits not zero.");

    property p_asm;
        @(posedge clock) disable iff (sys_rst)
        asm_write_valid && asm_instance == ASM_INPUT_INSTANCE
        |=> base_input_image == $past(asm_write_image);
    endproperty
    a_asm: assert property (p_asm) else $error("Assembly write lost.");

    property p_exch_fall;
        @(posedge clock) disable iff (sys_rst)
        $fell(exchange_active) |=> !asm_read_image[29];
    endproperty
    a_exch_fall: assert property (p_exch_fall) else $error("Exchange flag not cleared.");

    property p_port;
        @(posedge clock) disable iff (sys_rst)
        req_valid && req_tcp_port != MODBUS_TCP_PORT
        |=> !rsp_valid;
    endproperty
    a_port: assert property (p_port) else $error("Foreign port answered.");

    property p_span;
        @(posedge clock) disable iff (sys_rst)
        req_valid && req_tcp_port == MODBUS_TCP_PORT && req_function == FC_READ_HOLDING
        && req_read_count > IMAGE_WORDS_W
        |=> rsp_exception && rsp_exception_code == EXC_ILLEGAL_ADDRESS;
    endproperty
    a_span: assert property (p_span) else $error("Oversized read not refused.");

    property p_rst;
        @(posedge clock) disable iff (sys_rst)
        $past(sys_rst)
        |-> !rsp_valid && base_input_image == '0 && asm_read_image == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("Outputs not cleared by reset.");

    c_read: cover property (@(posedge clock) rsp_valid && !rsp_exception && state_reg.rsp_read);
    c_exc: cover property (@(posedge clock) rsp_valid && rsp_exception);
    c_asm: cover property (@(posedge clock)
        asm_write_valid && asm_instance == ASM_INPUT_INSTANCE);
    c_exch: cover property (@(posedge clock) $rose(asm_read_image[29]));
    c_write: cover property (@(posedge clock) req_write_strobe && !asm_write_valid);
endmodule
`default_nettype wire

//--- logic/fpim_pkg.sv
package fpim_pkg;
    // Modbus function codes accepted by the server side, and its exception codes.
    localparam logic [7:0] FC_READ_HOLDING = 8'h03;
    localparam logic [7:0] FC_WRITE_MULTIPLE = 8'h10;
    localparam logic [7:0] FC_READ_WRITE_MULTIPLE = 8'h17;
    localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
    // Register map, in 16-bit word addresses.
    localparam logic [15:0] INPUT_AREA_BASE = 16'h0000;
    localparam logic [15:0] OUTPUT_AREA_BASE = 16'h0400;
    // Image sizes.
    localparam int IMAGE_BYTES = 20;
    localparam int IMAGE_WORDS = 10;
    localparam logic [15:0] IMAGE_WORDS_W = 16'h000a;
    localparam int IO_POINTS = 24;
    // Status byte layout.
    localparam int STATUS_BYTE = 3;
    localparam int ST_OUTPUT_ERROR = 0;
    localparam int ST_INPUT_ERROR = 1;
    localparam int ST_GENERAL_ERROR = 2;
    localparam int ST_MAINTENANCE = 3;
    localparam int ST_RUNNING = 4;
    localparam int ST_EXCHANGE = 5;
    // Transport identifiers.
    localparam logic [15:0] MODBUS_TCP_PORT = 16'h01f6;
    localparam logic [7:0] ASM_OUTPUT_INSTANCE = 8'h64;
    localparam logic [7:0] ASM_INPUT_INSTANCE = 8'h96;
endpackage

//--- bench/fpim_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module fpim_master_model (
    input wire logic clock,
    output logic req_valid,
    output logic [15:0] req_tcp_port,
    output logic [7:0] req_function,
    output logic [15:0] req_read_addr,
    output logic [15:0] req_read_count,
    output logic [15:0] req_write_addr,
    output logic [15:0] req_write_count,
    output logic [15:0] req_write_word,
    output logic [3:0] req_write_index,
    output logic req_write_strobe,
    output logic asm_write_valid,
    output logic [7:0] asm_instance,
    output logic [159:0] asm_write_image
);
    initial begin
        {req_valid, req_write_strobe, asm_write_valid, asm_instance} = '0;
        {req_tcp_port, req_function, req_read_addr, req_read_count} = '0;
        {req_write_addr, req_write_count, req_write_word, req_write_index} = '0;
        asm_write_image = '0;
    end
    // Released function, address, data word and image fields are scrambled so stale values are never trusted; port, counts, index and instance are kept.
    task automatic request(input logic [7:0] fc, input logic [15:0] port, ra, rc, wa, wc);
        @(posedge clock);
        {req_valid, req_tcp_port, req_function} <= {1'b1, port, fc};
        {req_read_addr, req_read_count, req_write_addr, req_write_count} <= {ra, rc, wa, wc};
        @(posedge clock);
        {req_valid, req_function, req_read_addr, req_write_addr} <= {1'b0, ~fc, ~ra, ~wa};
    endtask
    task automatic write_word(input logic [3:0] idx, input logic [15:0] w);
        @(posedge clock);
        {req_write_strobe, req_write_index, req_write_word} <= {1'b1, idx, w};
        @(posedge clock);
        {req_write_strobe, req_write_word} <= {1'b0, ~w};
    endtask
    task automatic asm_write(input logic [7:0] inst, input logic [159:0] im);
        @(posedge clock);
        {asm_write_valid, asm_instance, asm_write_image} <= {1'b1, inst, im};
        @(posedge clock);
        {asm_write_valid, asm_write_image} <= {1'b0, ~im};
    endtask
endmodule
`default_nettype wire

//--- bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import fpim_pkg::*;
;
    logic clock, sys_rst, req_valid, req_write_strobe, asm_write_valid, rsp_valid, rsp_exception;
    logic output_error_led, input_error_led, general_error_led, maintenance_message_led;
    logic running_led, exchange_active;
    logic [15:0] req_tcp_port, req_read_addr, req_read_count, req_write_addr, req_write_count;
    logic [15:0] req_write_word, rsp_word, w;
    logic [7:0] req_function, asm_instance, rsp_exception_code;
    logic [3:0] req_write_index, rsp_word_index;
    logic [23:0] base_outputs, base_output_used, base_inputs;
    logic [159:0] asm_write_image, asm_read_image, base_input_image, img, exp;
    logic [4:0] leds;
    int num_errors = 0;
    int n_checks = 0;
    assign {running_led, maintenance_message_led, general_error_led} = leds[4:2];
    assign {input_error_led, output_error_led} = leds[1:0];
    fpim_map dut (.*);
    fpim_master_model master (.*);
    initial clock = 1'b0;
    always #12.5 clock = ~clock;
    // ----------------------------------------
    // Expectations and checking
    // ----------------------------------------
    function automatic logic [159:0] out_img(logic [23:0] o, u, logic [4:0] l, logic x);
        out_img = '0;
        out_img[31:0] = {2'b00, x, l, o & u};
    endfunction
    function automatic logic [15:0] word_of(logic [159:0] im, int k);
        word_of = {im[16*k +: 8], im[16*k+8 +: 8]};
    endfunction
    task automatic chk(input string name, input logic [159:0] e, g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h got %h", name, e, g);
        end
    endtask
    task automatic read_area(input logic [15:0] base, input logic [159:0] im);
        master.request(FC_READ_HOLDING, MODBUS_TCP_PORT, base, IMAGE_WORDS_W, 16'h0, 16'h1);
        #1 chk("rsp_valid", 1, rsp_valid);
        chk("rsp_exception", 0, rsp_exception);
        for (int k = 0; k < IMAGE_WORDS; k++) begin
            @(posedge clock);
            rsp_word_index <= k[3:0];
            #1 chk("rsp_word", word_of(im, k), rsp_word);
        end
    endtask
    task automatic expect_exc(input logic [7:0] fc, input logic [15:0] ra, rc,
                              input logic [7:0] c);
        master.request(fc, MODBUS_TCP_PORT, ra, rc, 16'h0, 16'h1);
        #1 chk("rsp_valid", 1, rsp_valid);
        chk("rsp_exception", c != 0, rsp_exception);
        chk("rsp_exception_code", c, rsp_exception_code);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'he66d));
        {sys_rst, base_outputs, base_output_used, leds, exchange_active} = {1'b1, 54'h0};
        rsp_word_index = 4'h0;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            base_outputs <= (i == 0) ? 24'h000021 : 24'($urandom);
            base_output_used <= (i == 0) ? 24'hffffff : 24'($urandom);
            {leds, exchange_active} <= (i == 1) ? 6'h3f : 6'($urandom);
            repeat (2) @(posedge clock);
            exp = out_img(base_outputs, base_output_used, leds, exchange_active);
            #1 chk("asm_read_image", exp, asm_read_image);
            chk("status_byte", {2'b00, exchange_active, leds}, asm_read_image[31:24]);
            chk("exchange_bit", exchange_active, asm_read_image[29]);
            chk("spare_bits", 0, asm_read_image[159:30]);
            if (i == 0) chk("output_number_five", 1, asm_read_image[5]);
        end
        read_area(OUTPUT_AREA_BASE, exp);
        img = {$urandom, $urandom, $urandom, $urandom, $urandom};
        master.asm_write(ASM_INPUT_INSTANCE, img);
        #1 chk("base_input_image", img, base_input_image);
        chk("base_inputs", img[23:0], base_inputs);
        master.asm_write(ASM_OUTPUT_INSTANCE, ~img);
        #1 chk("base_input_image", img, base_input_image);
        master.request(FC_WRITE_MULTIPLE, MODBUS_TCP_PORT, 16'h0, 16'h1, INPUT_AREA_BASE,
            IMAGE_WORDS_W);
        exp = img;
        for (int k = 0; k < IMAGE_WORDS; k++) begin
            w = (k == 0) ? 16'h0010 : 16'($urandom);
            exp[16*k +: 16] = {w[7:0], w[15:8]};
            master.write_word(k[3:0], w);
        end
        #1 chk("base_input_image", exp, base_input_image);
        chk("input_number_twelve", 1, base_inputs[12]);
        expect_exc(FC_READ_HOLDING, INPUT_AREA_BASE, 16'h1, EXC_ILLEGAL_ADDRESS);
        master.request(FC_WRITE_MULTIPLE, MODBUS_TCP_PORT, 16'h0, 16'h1, 16'h0009,
            16'h1);
        w = 16'($urandom);
        exp[16*9 +: 16] = {w[7:0], w[15:8]};
        master.write_word(4'h0, w);
        #1 chk("base_input_image", exp, base_input_image);
        exp = out_img(base_outputs, base_output_used, leds, exchange_active);
        read_area(OUTPUT_AREA_BASE, exp);
        expect_exc(8'h05, OUTPUT_AREA_BASE, IMAGE_WORDS_W, EXC_ILLEGAL_FUNCTION);
        expect_exc(FC_READ_HOLDING, 16'h0401, IMAGE_WORDS_W, EXC_ILLEGAL_ADDRESS);
        expect_exc(FC_READ_HOLDING, OUTPUT_AREA_BASE, 16'h0, EXC_ILLEGAL_ADDRESS);
        expect_exc(FC_READ_HOLDING, OUTPUT_AREA_BASE, 16'h000b, EXC_ILLEGAL_ADDRESS);
        expect_exc(FC_READ_WRITE_MULTIPLE, OUTPUT_AREA_BASE, IMAGE_WORDS_W, 8'h00);
        expect_exc(FC_WRITE_MULTIPLE, INPUT_AREA_BASE, 16'h1, 8'h00);
        master.request(FC_READ_HOLDING, 16'h01f7, OUTPUT_AREA_BASE, 16'h1, 16'h0,
            16'h1);
        #1 chk("rsp_valid", 0, rsp_valid);
        @(posedge clock);
        sys_rst <= 1'b1;
        @(posedge clock);
        sys_rst <= 1'b0;
        #1 chk("base_input_image", 0, base_input_image);
        chk("reset_asm_read_image", 0, asm_read_image);
        @(posedge clock);
        #1 chk("asm_read_image", exp, asm_read_image);
        report_and_stop();
    end
endmodule
`default_nettype wire
